/* design/ept_pkg.sv */
package ept_pkg;

  localparam logic [7:0] ADDR_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_COUNT   = 8'h33;
  localparam logic [7:0] ADDR_SCALING = 8'h34;
  localparam logic [7:0] ADDR_BOUND   = 8'h3f;

  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] BOUND_RESET  = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // Clock select codes.
  localparam logic [3:0] CS_STOP      = 4'h0;
  localparam logic [3:0] CS_SYSCLK    = 4'h1;
  localparam logic [3:0] CS_FAST_OSC  = 4'h2;
  localparam logic [3:0] CS_SLOW_OSC  = 4'h4;
  localparam logic [3:0] CS_COMPARE   = 4'h5;
  localparam logic [3:0] CS_PA0_RISE  = 4'h8;
  localparam logic [3:0] CS_PA0_FALL  = 4'h9;
  localparam logic [3:0] CS_PB0_RISE  = 4'ha;
  localparam logic [3:0] CS_PB0_FALL  = 4'hb;

  localparam logic [1:0] OUT_NONE     = 2'h0;
  localparam logic [1:0] OUT_PB5      = 2'h1;
  localparam logic [1:0] OUT_PB6      = 2'h2;
  localparam logic [1:0] OUT_PB7      = 2'h3;

  localparam logic [1:0] PRE_DIV1     = 2'h0;
  localparam logic [1:0] PRE_DIV4     = 2'h1;
  localparam logic [1:0] PRE_DIV16    = 2'h2;
  localparam logic [1:0] PRE_DIV64    = 2'h3;

  localparam logic [5:0] PRE_MAX4     = 6'h03;
  localparam logic [5:0] PRE_MAX16    = 6'h0f;
  localparam logic [5:0] PRE_MAX64    = 6'h3f;
  localparam logic [5:0] SIX_BIT_TOP  = 6'h3f;

  typedef struct packed {
    logic [3:0] clk_sel;
    logic [1:0] out_sel;
    logic       pwm_mode;
    logic       invert;
  } ept_control_t;

  typedef struct packed {
    logic       res_six;
    logic [1:0] prescale;
    logic [4:0] scaler;
  } ept_scaling_t;

  localparam ept_control_t CONTROL_RESET = '{4'h0, 2'h0, 1'b0, 1'b0};
  localparam ept_scaling_t SCALING_RESET = '{1'b0, 2'h0, 5'h00};

  typedef struct packed {
    logic port_a_bit_zero;
    logic port_b_bit_zero;
    logic internal_fast_oscillator;
    logic internal_slow_oscillator;
    logic comparator;
  } ept_sources_t;

endpackage

/* design/ept_tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// Divides raw source ticks by the prescaler, then by the five-bit scaler.
module ept_tick_divider
  import ept_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_rstn,
  input  wire logic           i_tick,
  input  wire logic           i_clear,
  input  wire ept_scaling_t   i_scaling,
  output logic                o_tick
);

  logic [5:0] pre_count;
  logic [4:0] scl_count;
  logic [5:0] pre_max;
  logic       pre_done;
  logic       scl_done;

  assign pre_max  = (i_scaling.prescale == PRE_DIV1)  ? 6'h00 :
                    (i_scaling.prescale == PRE_DIV4)  ? PRE_MAX4 :
                    (i_scaling.prescale == PRE_DIV16) ? PRE_MAX16 :
                                                        PRE_MAX64;
  assign pre_done = i_tick && (pre_count >= pre_max);
  // Scaler value N divides by N+1, so zero passes every prescaled tick.
  assign scl_done = pre_done && (scl_count >= i_scaling.scaler);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || i_clear) begin
      pre_count <= 6'h00;
      scl_count <= 5'h00;
      o_tick    <= 1'b0;
    end else begin
      o_tick <= scl_done; // [RULE10]
      if (i_tick)
        pre_count <= pre_done ? 6'h00 : pre_count + 6'h01; // [RULE8]
      if (pre_done)
        scl_count <= scl_done ? 5'h00 : scl_count + 5'h01; // [RULE8]
    end
  end

  a_tick_needs_src: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_tick |-> $past(i_tick)) else $error("divided tick without source"); // [RULE10]

endmodule
`default_nettype wire

/* design/ept_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Bits 7-4 of control pick the counting source: stop, system clock, fast oscillator, slow oscillator or comparator.
// [RULE2] Codes 1000 to 1011 count rising or falling edges of port A bit 0 or port B bit 0.
// [RULE3] With the fast oscillator selected the timer keeps counting while the emulator is halted.
// [RULE4] Control bits 3-2 route the output to nothing, port B bit five, six or seven.
// [RULE5] Control bit 1 picks period mode at 0 and PWM mode at 1, resetting to 0.
// [RULE6] Control bit 0 inverts the timer output and resets clear.
// [RULE7] The counter is readable and writable, resets to 0x00, and a write loads it.
// [RULE8] The write-only scaling register holds PWM resolution, prescale and five-bit scaler, all reset zero.
// [RULE9] A write-only bound register resetting to 0x00 sets the counting bound in period mode and the duty in PWM mode.
// [RULE10] The counter steps once per divided tick and holds while the source is stopped.
module ept_timer
  import ept_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_rstn,
  input  wire logic [7:0]     i_io_addr,
  input  wire logic [7:0]     i_io_wdata,
  input  wire logic           i_io_wr,
  input  wire logic           i_io_rd,
  input  wire ept_sources_t   i_sources,
  input  wire logic           i_emulator_halt,
  output logic [7:0]          o_io_rdata,
  output logic                o_port_b_bit_five,
  output logic                o_port_b_bit_six,
  output logic                o_port_b_bit_seven,
  output logic [2:0]          o_port_b_oe
);
  import ept_pkg::*;

  ept_control_t control;
  ept_scaling_t scaling;
  logic [7:0]   count;
  logic [7:0]   bound;
  logic         pa0_q;
  logic         pb0_q;
  logic         fast_q;
  logic         slow_q;
  logic         cmp_q;
  logic         pwm_level;

  wire wr_control = i_io_wr && (i_io_addr == ADDR_CONTROL);
  wire wr_count   = i_io_wr && (i_io_addr == ADDR_COUNT);
  wire wr_scaling = i_io_wr && (i_io_addr == ADDR_SCALING);
  wire wr_bound   = i_io_wr && (i_io_addr == ADDR_BOUND);

  function automatic logic rise(input logic now, input logic was);
    return now && !was;
  endfunction

  // Internal clocks arrive as levels; a rising edge is one source tick.
  // The emulator halt input is deliberately ignored for the fast source.
  wire src_fast = rise(i_sources.internal_fast_oscillator, fast_q); // [RULE3]
  wire halt_ok  = !i_emulator_halt;

  logic raw_tick;
  always_comb begin
    case (control.clk_sel) // [RULE1] [RULE2]
      CS_STOP:     raw_tick = 1'b0;
      CS_SYSCLK:   raw_tick = halt_ok;
      CS_FAST_OSC: raw_tick = src_fast;
      CS_SLOW_OSC: raw_tick = halt_ok &&
                      rise(i_sources.internal_slow_oscillator, slow_q);
      CS_COMPARE:  raw_tick = halt_ok && rise(i_sources.comparator, cmp_q);
      CS_PA0_RISE: raw_tick = halt_ok && rise(i_sources.port_a_bit_zero, pa0_q);
      CS_PA0_FALL: raw_tick = halt_ok && rise(pa0_q, i_sources.port_a_bit_zero);
      CS_PB0_RISE: raw_tick = halt_ok && rise(i_sources.port_b_bit_zero, pb0_q);
      CS_PB0_FALL: raw_tick = halt_ok && rise(pb0_q, i_sources.port_b_bit_zero);
      default:     raw_tick = 1'b0;
    endcase
  end

  logic tick;
  ept_tick_divider u_div (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_tick    (raw_tick),
    .i_clear   (wr_scaling),
    .i_scaling (scaling),
    .o_tick    (tick)
  );

  // In six-bit PWM resolution the counter wraps at 63 and the bound's low bits
  // set the duty; period mode clears on reaching the bound.
  wire [7:0] top_val   = scaling.res_six ? {2'b00, SIX_BIT_TOP} : 8'hff;
  wire [7:0] cmp_bound = scaling.res_six ? {2'b00, bound[5:0]} : bound;
  wire       at_top    = control.pwm_mode ? (count == top_val)
                                          : (count == bound);
  wire [7:0] next_count = wr_count ? i_io_wdata :
                          (tick && control.clk_sel != CS_STOP) ?
                          (at_top ? ZERO_BYTE : count + 8'h01) : count;
  wire next_pwm_level = control.pwm_mode ? (next_count < cmp_bound)
                       : ((tick && at_top) ? !pwm_level : pwm_level);
  wire out_level = pwm_level ^ control.invert; // [RULE6]

  logic [7:0] rd_mux;
  always_comb begin
    case (i_io_addr)
      ADDR_CONTROL: rd_mux = control;
      ADDR_COUNT:   rd_mux = count; // [RULE7]
      default:      rd_mux = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      control   <= CONTROL_RESET; // [RULE5] [RULE6]
      scaling   <= SCALING_RESET; // [RULE8]
      bound     <= BOUND_RESET; // [RULE9]
      count     <= COUNT_RESET; // [RULE7]
      pa0_q     <= 1'b0;
      pb0_q     <= 1'b0;
      fast_q    <= 1'b0;
      slow_q    <= 1'b0;
      cmp_q     <= 1'b0;
      pwm_level <= 1'b0;
      o_io_rdata <= ZERO_BYTE;
      o_port_b_bit_five  <= 1'b0;
      o_port_b_bit_six   <= 1'b0;
      o_port_b_bit_seven <= 1'b0;
      o_port_b_oe        <= 3'h0;
    end else begin
      if (wr_control) control <= i_io_wdata;
      if (wr_scaling) scaling <= i_io_wdata; // [RULE8]
      if (wr_bound)   bound   <= i_io_wdata; // [RULE9]
      count     <= next_count; // [RULE7] [RULE10]
      pwm_level <= next_pwm_level; // [RULE5]
      pa0_q  <= i_sources.port_a_bit_zero;
      pb0_q  <= i_sources.port_b_bit_zero;
      fast_q <= i_sources.internal_fast_oscillator;
      slow_q <= i_sources.internal_slow_oscillator;
      cmp_q  <= i_sources.comparator;
      o_io_rdata <= i_io_rd ? rd_mux : ZERO_BYTE;
      o_port_b_bit_five  <= (control.out_sel == OUT_PB5) && out_level; // [RULE4]
      o_port_b_bit_six   <= (control.out_sel == OUT_PB6) && out_level; // [RULE4]
      o_port_b_bit_seven <= (control.out_sel == OUT_PB7) && out_level; // [RULE4]
      o_port_b_oe <= {control.out_sel == OUT_PB7, control.out_sel == OUT_PB6,
                      control.out_sel == OUT_PB5}; // [RULE4]
    end
  end

  a_stop_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (control.clk_sel == CS_STOP && !wr_count && !wr_control)
    |=> count == $past(count)) else $error("count moved while stopped"); // [RULE10]
  a_count_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    wr_count |=> count == $past(i_io_wdata)) else $error("count not loaded"); // [RULE7]
  a_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (tick && !wr_count && !at_top && control.clk_sel != CS_STOP)
    |=> count == $past(count) + 8'h01) else $error("count did not step"); // [RULE10]
  a_fast_in_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (control.clk_sel == CS_FAST_OSC && src_fast) |-> raw_tick)
    else $error("fast source blocked"); // [RULE3]
  a_halt_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_emulator_halt && control.clk_sel == CS_SYSCLK) |-> !raw_tick)
    else $error("system clock ticked in halt"); // [RULE1]
  a_pa0_rise: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (control.clk_sel == CS_PA0_RISE && !i_emulator_halt &&
     i_sources.port_a_bit_zero && !pa0_q) |-> raw_tick)
    else $error("missed pin edge"); // [RULE2]
  a_out_route: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (control.out_sel == OUT_NONE) |=> o_port_b_oe == 3'h0)
    else $error("output driven while off"); // [RULE4]
  a_out_invert: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (control.out_sel == OUT_PB5) |=>
    o_port_b_bit_five == ($past(pwm_level) ^ $past(control.invert)))
    else $error("wrong output polarity"); // [RULE6]
  a_pwm_compare: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    control.pwm_mode |=> pwm_level == (count < $past(cmp_bound)))
    else $error("pwm level mismatch"); // [RULE5] [RULE9]
  a_scale_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !wr_scaling |=> scaling == $past(scaling))
    else $error("scaling changed without write"); // [RULE8]

endmodule
`default_nettype wire

/* sim/ept_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Drives the external pins and internal tick sources; all idle low.
module ept_pin_model
  import ept_pkg::*;
(
  input  wire logic   i_clk_sys,
  output var ept_sources_t o_sources
);
  logic [4:0] lvl = 5'h00;
  assign o_sources = lvl;
  // One rising and one falling edge per pulse, so both edge codes see n.
  task automatic pulse(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk_sys);
      lvl[idx] <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      lvl[idx] <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ept_pkg::*;
  logic         i_clk_sys, i_rstn, i_io_wr, i_io_rd, i_emulator_halt;
  logic [7:0]   i_io_addr, i_io_wdata, o_io_rdata, got;
  logic         o_b5, o_b6, o_b7;
  logic [2:0]   o_port_b_oe, oe_e;
  ept_sources_t i_sources;
  int           mismatches = 0;
  int           checks = 0;
  logic [3:0]   cs_tab [7] = '{CS_PA0_RISE, CS_PA0_FALL, CS_PB0_RISE,
                               CS_PB0_FALL, CS_FAST_OSC, CS_SLOW_OSC,
                               CS_COMPARE};
  int           ix_tab [7] = '{4, 4, 3, 3, 2, 1, 0};
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  ept_pin_model i_pins (.i_clk_sys(i_clk_sys), .o_sources(i_sources));
  ept_timer i_dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_sources(i_sources), .i_emulator_halt(i_emulator_halt),
    .o_io_rdata(o_io_rdata), .o_port_b_bit_five(o_b5),
    .o_port_b_bit_six(o_b6), .o_port_b_bit_seven(o_b7),
    .o_port_b_oe(o_port_b_oe));
  task complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_io_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the read edge.
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_io_addr <= a;
    i_io_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_io_rd <= 1'b0;
    #1 got = o_io_rdata;
  endtask
  task automatic chk8(input logic [7:0] e, input string m);
    checks++;
    if (got !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, e);
    end
  endtask
  task automatic chk6(input logic [5:0] g, input logic [5:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: pins got %h exp %h", $time, g, e);
    end
  endtask
  // Counting is stopped before the read so the value cannot move under it.
  task automatic cnt(input logic [7:0] sc, input logic [3:0] cs,
                     input int idx, input int n, input logic [7:0] e);
    wr(ADDR_SCALING, sc);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL, {cs, 4'h0});
    i_pins.pulse(idx, n);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT);
    chk8(e, "count");
  endtask
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    complete_run();
  end
  initial begin
    i_rstn = 1'b0;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    i_io_addr = 8'h00;
    i_io_wdata = 8'h00;
    i_emulator_halt = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    rd(ADDR_CONTROL); chk8(8'h00, "control reset");
    rd(ADDR_COUNT); chk8(COUNT_RESET, "count reset");
    rd(ADDR_SCALING); chk8(ZERO_BYTE, "scaling read");
    rd(ADDR_BOUND); chk8(ZERO_BYTE, "bound read");
    wr(8'h35, 8'hff);
    rd(8'h35); chk8(ZERO_BYTE, "unmapped read");
    rd(ADDR_CONTROL); chk8(8'h00, "unmapped write");
    wr(ADDR_CONTROL, 8'hb7);
    rd(ADDR_CONTROL); chk8(8'hb7, "control");
    wr(ADDR_COUNT, 8'ha5);
    rd(ADDR_COUNT); chk8(8'ha5, "count load");
    $display("test registers done");
    wr(ADDR_BOUND, 8'hff);
    for (int i = 0; i < 7; i++) cnt(8'h00, cs_tab[i], ix_tab[i], 5, 8'h05);
    cnt(8'h00, 4'h3, 2, 5, 8'h00);
    cnt(8'h00, CS_STOP, 4, 5, 8'h00);
    cnt(8'h20, CS_PA0_RISE, 4, 8, 8'h02);
    cnt(8'h02, CS_PA0_RISE, 4, 6, 8'h02);
    $display("test sources done");
    wr(ADDR_BOUND, 8'h03);
    cnt(8'h00, CS_PB0_RISE, 3, 6, 8'h02);
    // A low bound would wrap the halt counts, so open it up again first.
    wr(ADDR_BOUND, 8'hff);
    i_emulator_halt <= 1'b1;
    cnt(8'h00, CS_FAST_OSC, 2, 4, 8'h04);
    cnt(8'h00, CS_PA0_RISE, 4, 4, 8'h00);
    i_emulator_halt <= 1'b0;
    $display("test bound and halt done");
    wr(ADDR_BOUND, 8'h00);
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        wr(ADDR_CONTROL, {4'h0, s[1:0], 1'b1, v[0]});
        repeat (3) @(posedge i_clk_sys);
        #1 oe_e = (s == 0) ? 3'b000 : 3'(1 << (s - 1));
        chk6({o_port_b_oe, o_b7, o_b6, o_b5}, {oe_e, oe_e & {3{v[0]}}});
      end
    end
    wr(ADDR_BOUND, 8'hff);
    wr(ADDR_CONTROL, 8'h06);
    repeat (3) @(posedge i_clk_sys);
    #1 chk6({o_port_b_oe, o_b7, o_b6, o_b5}, 6'h09);
    // Six-bit resolution compares only the bound's low six bits, here zero.
    wr(ADDR_SCALING, 8'h80);
    wr(ADDR_BOUND, 8'hc0);
    repeat (3) @(posedge i_clk_sys);
    #1 chk6({o_port_b_oe, o_b7, o_b6, o_b5}, 6'h08);
    $display("test outputs done");
    complete_run();
  end
endmodule
`default_nettype wire
